// File: alu_latch_pkg.sv
/*
 * Constants shared by the latching four-bit ALU: register offsets, field
 * positions, reset values and the AHB-Lite codes used on the slave bus.
 * Assumes a 32-bit AHB-Lite bus with one word per register.
 */
package alu_latch_pkg;

	// ==========================================================
	// Datapath widths
	localparam int WORD_W = 4;
	localparam int FUNC_W = 4;

	// ==========================================================
	// Register byte addresses
	localparam logic [31:0] ADDR_OPERAND = 32'h0000_0000;
	localparam logic [31:0] ADDR_STATUS = 32'h0000_0004;

	// ==========================================================
	// Operand register fields
	localparam int OP_FIRST_LSB = 0;
	localparam int OP_SECOND_LSB = 4;
	localparam int OP_FUNC_LSB = 8;
	localparam int OP_MODE_BIT = 12;
	localparam int OP_CIN_BIT = 13;
	localparam int OP_SRC_BIT = 16;
	localparam int OP_HOLD_BIT = 17;

	// ==========================================================
	// Status register fields
	localparam int ST_RESULT_LSB = 0;
	localparam int ST_GEN_BIT = 4;
	localparam int ST_PROP_BIT = 5;
	localparam int ST_COUT_BIT = 6;
	localparam int ST_HOLD_BIT = 7;

	// ==========================================================
	// Reset values
	localparam logic [WORD_W-1:0] RST_WORD = 4'h0;
	localparam logic [FUNC_W-1:0] RST_FUNC = 4'h0;
	localparam logic RST_MODE = 1'b0;
	localparam logic RST_CIN_N = 1'b1;
	localparam logic RST_SRC = 1'b0;
	localparam logic RST_HOLD = 1'b1;

	// ==========================================================
	// AHB-Lite codes
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] HTRANS_SEQ = 2'h3;
	localparam logic [2:0] HSIZE_WORD = 3'h2;
	localparam logic HRESP_OKAY = 1'b0;
	localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

endpackage

// File: alu_slice.sv
/*
 * Four-bit ALU slice: sixteen logic and sixteen arithmetic functions,
 * block generate and propagate, and the top carry-out. Purely combinational.
 * Assumes the caller registers whatever it needs.
 */
`timescale 1ns/1ps
`default_nettype none
module alu_slice
	import alu_latch_pkg::*;
#(
	parameter int WIDTH = WORD_W
) (
	// Operands
	input wire logic [WIDTH-1:0] first_word_bits_i,
	input wire logic [WIDTH-1:0] second_word_lines_i,
	// Function select
	input wire logic [FUNC_W-1:0] function_code_i,
	input wire logic mode_i,
	input wire logic carry_in_low_true_i,
	// Results
	output logic [WIDTH-1:0] result_o,
	output logic block_gen_o,
	output logic block_prop_o,
	output logic carry_out_top_n_o
);

	// ==========================================================
	// Operand shaping
	logic [WIDTH-1:0] or_term; // Per-bit propagate, addend one
	logic [WIDTH-1:0] and_term; // Per-bit generate, addend two
	logic [WIDTH:0] sum; // Arithmetic sum with carry

	// Addend and logic terms from function code and operands
	always_comb begin
		or_term = first_word_bits_i | (second_word_lines_i & {WIDTH{function_code_i[1]}})
			| (~second_word_lines_i & {WIDTH{function_code_i[0]}});
		and_term = (first_word_bits_i & second_word_lines_i & {WIDTH{function_code_i[2]}})
			| (first_word_bits_i & ~second_word_lines_i & {WIDTH{function_code_i[3]}});
		// Carry-in is low-true, so low adds one
		sum = {1'b0, or_term} + {1'b0, and_term} + {{WIDTH{1'b0}}, ~carry_in_low_true_i};
		// Mode high picks logic, low picks arithmetic
		if (mode_i) begin
			result_o = ~(or_term ^ and_term);
		end else begin
			result_o = sum[WIDTH-1:0];
		end
		// Block look-ahead terms, free of the carry-in
		block_gen_o = 1'b0;
		for (int i = 0; i < WIDTH; i++) begin
			block_gen_o = and_term[i] | (or_term[i] & block_gen_o);
		end
		block_prop_o = &or_term;
		carry_out_top_n_o = ~sum[WIDTH];
	end

endmodule
`default_nettype wire

// File: result_hold.sv
/*
 * Hold register for the four result lines: follows the ALU while the hold
 * control is high and keeps its value while it is low.
 * Assumes hold and data come from logic on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
module result_hold
	import alu_latch_pkg::*;
#(
	parameter int WIDTH = WORD_W
) (
	// Clock, reset, enable
	input wire logic clk_sys_i,
	input wire logic reset_n_i,
	input wire logic ce_i,
	// Data and hold control
	input wire logic hold_enable_i,
	input wire logic [WIDTH-1:0] result_i,
	output logic [WIDTH-1:0] result_o
);

	// ==========================================================
	// Held value
	logic [WIDTH-1:0] held_r; // Stored result
	logic [WIDTH-1:0] held_nxt; // Next stored result

	// Pass when enabled, keep otherwise
	always_comb begin
		held_nxt = held_r;
		if (ce_i && hold_enable_i) begin
			held_nxt = result_i;
		end
		// Low control keeps the old value whatever inputs do
	end

	// Register stage
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			held_r <= RST_WORD[WIDTH-1:0];
		end else begin
			held_r <= held_nxt;
		end
	end

	assign result_o = held_r;

endmodule
`default_nettype wire

// File: latching_four_bit_alu.sv
/*
 * Latching four-bit ALU with an AHB-Lite register slave. The ALU inputs come
 * either from pins or from the operand register; the result passes a hold
 * register, the look-ahead outputs do not.
 * Assumes pin inputs are driven by logic on clk_sys_i and that the bus master
 * issues single word transfers.
 */
// Notes on behaviour
// - Add, subtract or any logic on 4-bit words
// - Mode low arithmetic, mode high logic
// - Output block generate, propagate and top carry-out
// - Hold control high passes result through
// - Hold control low keeps result unchanged
// - Input changes never disturb a held result
// - No equality output; hold control instead
// - Code 0110: sum or XNOR
// - Code 1001: A minus B minus one or XOR
// - Code 0011: all ones or all zeros
// - Code 1111: A minus one or A
// - Generate and propagate ignore the carry-in
`timescale 1ns/1ps
`default_nettype none
module latching_four_bit_alu
	import alu_latch_pkg::*;
#(
	parameter int WIDTH = WORD_W
) (
	// Clock, reset and clock enable
	input wire logic clk_sys_i,
	input wire logic reset_n_i,
	input wire logic ce_i,

	// ALU operand pins
	input wire logic [WIDTH-1:0] first_word_bits_i,
	input wire logic [WIDTH-1:0] second_word_lines_i,
	input wire logic [alu_latch_pkg::FUNC_W-1:0] function_code_i,
	input wire logic mode_i,
	input wire logic carry_in_low_true_i,
	input wire logic hold_enable_i,

	// ALU outputs
	output logic [WIDTH-1:0] result_outputs_o,
	output logic block_gen_o,
	output logic block_prop_o,
	output logic carry_out_top_n_o,

	// AHB-Lite slave
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o
);

	// ==========================================================
	// Operand register state
	logic [WIDTH-1:0] first_r; // Software first word
	logic [WIDTH-1:0] first_nxt;
	logic [WIDTH-1:0] second_r; // Software second word
	logic [WIDTH-1:0] second_nxt;
	logic [FUNC_W-1:0] func_r; // Software function code
	logic [FUNC_W-1:0] func_nxt;
	logic mode_r; // Software mode
	logic mode_nxt;
	logic cin_n_r; // Software low-true carry-in
	logic cin_n_nxt;
	logic src_r; // High: registers feed the ALU
	logic src_nxt;
	logic hold_r; // Software hold control
	logic hold_nxt;

	// ==========================================================
	// Bus state
	logic wr_pend_r; // Write data phase pending
	logic wr_pend_nxt;
	logic [31:0] wr_addr_r; // Address of pending write
	logic [31:0] wr_addr_nxt;
	logic [31:0] rdata_r; // Read data for data phase
	logic [31:0] rdata_nxt;
	logic ready_r; // Registered ready
	logic addr_phase; // Valid transfer taken this cycle

	// ==========================================================
	// Look-ahead output state
	logic gen_r;
	logic gen_nxt;
	logic prop_r;
	logic prop_nxt;
	logic cout_n_r;
	logic cout_n_nxt;

	// ==========================================================
	// Datapath wiring
	logic [WIDTH-1:0] alu_a; // Selected first word
	logic [WIDTH-1:0] alu_b; // Selected second word
	logic [FUNC_W-1:0] alu_fc; // Selected function code
	logic alu_mode; // Selected mode
	logic alu_cin_n; // Selected carry-in
	logic alu_hold; // Selected hold control
	logic [WIDTH-1:0] alu_f; // Raw ALU result
	logic alu_g;
	logic alu_p;
	logic alu_cout_n;
	logic [WIDTH-1:0] held_result; // Result after hold

	// Packs the operand register for reads
	function automatic logic [31:0] pack_operand(
		input logic [WIDTH-1:0] a,
		input logic [WIDTH-1:0] b,
		input logic [FUNC_W-1:0] fc,
		input logic m,
		input logic c,
		input logic s,
		input logic h
	);
		logic [31:0] w;
		w = RDATA_ZERO;
		w[OP_FIRST_LSB +: WIDTH] = a;
		w[OP_SECOND_LSB +: WIDTH] = b;
		w[OP_FUNC_LSB +: FUNC_W] = fc;
		w[OP_MODE_BIT] = m;
		w[OP_CIN_BIT] = c;
		w[OP_SRC_BIT] = s;
		w[OP_HOLD_BIT] = h;
		return w;
	endfunction

	// Packs the status register for reads
	function automatic logic [31:0] pack_status(
		input logic [WIDTH-1:0] q,
		input logic g,
		input logic p,
		input logic c,
		input logic h
	);
		logic [31:0] w;
		w = RDATA_ZERO;
		w[ST_RESULT_LSB +: WIDTH] = q;
		w[ST_GEN_BIT] = g;
		w[ST_PROP_BIT] = p;
		w[ST_COUT_BIT] = c;
		w[ST_HOLD_BIT] = h;
		return w;
	endfunction

	// ==========================================================
	// Input selection
	// Registers or pins feed the ALU; the hold control
	// sits where an equality output would otherwise be
	always_comb begin
		if (src_r) begin
			alu_a = first_r;
			alu_b = second_r;
			alu_fc = func_r;
			alu_mode = mode_r;
			alu_cin_n = cin_n_r;
			alu_hold = hold_r;
		end else begin
			alu_a = first_word_bits_i;
			alu_b = second_word_lines_i;
			alu_fc = function_code_i;
			alu_mode = mode_i;
			alu_cin_n = carry_in_low_true_i;
			// Pin clocked with downstream latch enable
			alu_hold = hold_enable_i;
		end
	end

	// ==========================================================
	// ALU slice
	alu_slice #(
		.WIDTH(WIDTH)
	) u_slice (
		.first_word_bits_i(alu_a),
		.second_word_lines_i(alu_b),
		.function_code_i(alu_fc),
		.mode_i(alu_mode),
		.carry_in_low_true_i(alu_cin_n),
		.result_o(alu_f),
		.block_gen_o(alu_g),
		.block_prop_o(alu_p),
		.carry_out_top_n_o(alu_cout_n)
	);

	// ==========================================================
	// Result hold, result lines only
	result_hold #(
		.WIDTH(WIDTH)
	) u_hold (
		.clk_sys_i(clk_sys_i),
		.reset_n_i(reset_n_i),
		.ce_i(ce_i),
		.hold_enable_i(alu_hold),
		.result_i(alu_f),
		.result_o(held_result)
	);

	// ==========================================================
	// Look-ahead outputs
	// Follow the ALU every enabled cycle, hold or not
	always_comb begin
		gen_nxt = gen_r;
		prop_nxt = prop_r;
		cout_n_nxt = cout_n_r;
		if (ce_i) begin
			gen_nxt = alu_g;
			prop_nxt = alu_p;
			cout_n_nxt = alu_cout_n;
		end
	end

	// Register stage for look-ahead outputs
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			gen_r <= 1'b0;
			prop_r <= 1'b0;
			cout_n_r <= 1'b1;
		end else begin
			gen_r <= gen_nxt;
			prop_r <= prop_nxt;
			cout_n_r <= cout_n_nxt;
		end
	end

	// ==========================================================
	// AHB-Lite address phase decode
	assign addr_phase = hsel_i && hready_i && htrans_i[1];

	// Bus next state: capture writes, prepare read data
	always_comb begin
		wr_pend_nxt = wr_pend_r;
		wr_addr_nxt = wr_addr_r;
		rdata_nxt = rdata_r;
		if (ce_i) begin
			wr_pend_nxt = 1'b0;
			if (addr_phase && hwrite_i) begin
				// Write takes effect in the data phase
				wr_pend_nxt = 1'b1;
				wr_addr_nxt = haddr_i;
				rdata_nxt = RDATA_ZERO;
			end else if (addr_phase) begin
				// Read data loaded now, shown in data phase
				if (haddr_i == ADDR_OPERAND) begin
					// Next values, so a write still in its data phase is seen
					rdata_nxt = pack_operand(first_nxt, second_nxt, func_nxt, mode_nxt,
						cin_n_nxt, src_nxt, hold_nxt);
				end else if (haddr_i == ADDR_STATUS) begin
					rdata_nxt = pack_status(held_result, gen_r, prop_r, cout_n_r,
						alu_hold);
				end else begin
					// Unmapped reads give zero
					rdata_nxt = RDATA_ZERO;
				end
			end
		end
	end

	// Bus register stage
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			wr_pend_r <= 1'b0;
			wr_addr_r <= ADDR_OPERAND;
			rdata_r <= RDATA_ZERO;
			ready_r <= 1'b0;
		end else begin
			wr_pend_r <= wr_pend_nxt;
			wr_addr_r <= wr_addr_nxt;
			rdata_r <= rdata_nxt;
			// Zero wait states from the first edge after reset
			ready_r <= 1'b1;
		end
	end

	// ==========================================================
	// Operand register writes
	always_comb begin
		first_nxt = first_r;
		second_nxt = second_r;
		func_nxt = func_r;
		mode_nxt = mode_r;
		cin_n_nxt = cin_n_r;
		src_nxt = src_r;
		hold_nxt = hold_r;
		// Status and unmapped writes are ignored
		if (ce_i && wr_pend_r && wr_addr_r == ADDR_OPERAND) begin
			first_nxt = hwdata_i[OP_FIRST_LSB +: WIDTH];
			second_nxt = hwdata_i[OP_SECOND_LSB +: WIDTH];
			func_nxt = hwdata_i[OP_FUNC_LSB +: FUNC_W];
			mode_nxt = hwdata_i[OP_MODE_BIT];
			cin_n_nxt = hwdata_i[OP_CIN_BIT];
			src_nxt = hwdata_i[OP_SRC_BIT];
			hold_nxt = hwdata_i[OP_HOLD_BIT];
		end
	end

	// Operand register stage
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			first_r <= RST_WORD[WIDTH-1:0];
			second_r <= RST_WORD[WIDTH-1:0];
			func_r <= RST_FUNC;
			mode_r <= RST_MODE;
			cin_n_r <= RST_CIN_N;
			src_r <= RST_SRC;
			hold_r <= RST_HOLD;
		end else begin
			first_r <= first_nxt;
			second_r <= second_nxt;
			func_r <= func_nxt;
			mode_r <= mode_nxt;
			cin_n_r <= cin_n_nxt;
			src_r <= src_nxt;
			hold_r <= hold_nxt;
		end
	end

	// ==========================================================
	// Output drive, all from flip-flops except the constant hresp_o
	assign result_outputs_o = held_result;
	assign block_gen_o = gen_r;
	assign block_prop_o = prop_r;
	assign carry_out_top_n_o = cout_n_r;
	assign hrdata_o = rdata_r;
	assign hreadyout_o = ready_r;
	assign hresp_o = HRESP_OKAY;

endmodule
`default_nettype wire

// File: alu_latch_asserts.sv
/* Checker for the latching ALU ports.
   Assumes one AHB-Lite master doing single word transfers. */
`timescale 1ns/1ps
`default_nettype none
module alu_latch_asserts
	import alu_latch_pkg::*;
#(
	parameter int WIDTH = WORD_W
) (
	// Clock, reset, enable
	input wire logic clk_sys_i,
	input wire logic reset_n_i,
	input wire logic ce_i,
	// Operand pins
	input wire logic [WIDTH-1:0] first_word_bits_i,
	input wire logic [WIDTH-1:0] second_word_lines_i,
	input wire logic [FUNC_W-1:0] function_code_i,
	input wire logic mode_i,
	input wire logic carry_in_low_true_i,
	input wire logic hold_enable_i,
	// ALU outputs
	input wire logic [WIDTH-1:0] result_outputs_o,
	input wire logic block_gen_o,
	input wire logic block_prop_o,
	input wire logic carry_out_top_n_o,
	// Bus, for the source select
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i
);
	// Reference slice: {cout_n, prop, gen, result}
	function automatic logic [6:0] alu_f(input logic [3:0] a, b, s, input logic m, cn);
		logic [3:0] o;
		logic [3:0] n;
		logic [4:0] sum;
		o = a | (b & {4{s[1]}}) | (~b & {4{s[0]}});
		n = (a & b & {4{s[2]}}) | (a & ~b & {4{s[3]}});
		sum = {1'b0, o} + {1'b0, n} + {4'h0, ~cn};
		alu_f[3:0] = m ? ~(o ^ n) : sum[3:0];
		alu_f[4] = n[3] | o[3] & n[2] | o[3] & o[2] & n[1] | (&o[3:1]) & n[0];
		alu_f[5] = &o;
		alu_f[6] = ~sum[4];
	endfunction

	// ==========================================================
	// Helper logic
	logic wr_pend_r; // Operand write in data phase
	logic src_r; // Registers drive the ALU
	logic [3:0] a;
	logic [3:0] b;
	logic [6:0] exp_w; // Expected outputs
	logic pin_w; // Pins drive the ALU
	logic pass_w; // Pins drive, hold open
	logic code_w; // Pass with carry-in idle in arithmetic
	assign a = first_word_bits_i;
	assign b = second_word_lines_i;
	assign exp_w = alu_f(a, b, function_code_i, mode_i, carry_in_low_true_i);
	assign pin_w = reset_n_i && ce_i && !src_r;
	assign pass_w = pin_w && hold_enable_i;
	assign code_w = pass_w && (mode_i || carry_in_low_true_i);

	// Track the source select bit of operand writes
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			wr_pend_r <= 1'b0;
			src_r <= 1'b0;
		end else if (ce_i) begin
			if (wr_pend_r) begin
				src_r <= hwdata_i[OP_SRC_BIT];
			end
			wr_pend_r <= hsel_i && hready_i && htrans_i[1] && hwrite_i && haddr_i == ADDR_OPERAND;
		end
	end

	// ==========================================================
	// Properties
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!reset_n_i);

	sequence s_held;
		(ce_i && !src_r && !hold_enable_i)[*3];
	endsequence

	property p_pass;
		$past(pass_w) |-> result_outputs_o == $past(exp_w[3:0]);
	endproperty
	property p_hold;
		$past(reset_n_i && !src_r && !hold_enable_i) |-> $stable(result_outputs_o);
	endproperty
	property p_freeze;
		s_held |=> result_outputs_o == $past(result_outputs_o, 2);
	endproperty
	property p_gp;
		$past(pin_w) |-> {block_prop_o, block_gen_o} == $past(exp_w[5:4]);
	endproperty
	property p_cout;
		$past(pin_w && !mode_i) |-> carry_out_top_n_o == $past(exp_w[6]);
	endproperty
	property p_add;
		$past(code_w && function_code_i == 4'h6) |->
			result_outputs_o == $past(mode_i ? ~(a ^ b) : a + b);
	endproperty
	property p_sub;
		$past(code_w && function_code_i == 4'h9) |->
			result_outputs_o == $past(mode_i ? a ^ b : a - b - 4'h1);
	endproperty
	property p_ones;
		$past(code_w && function_code_i == 4'h3) |->
			result_outputs_o == $past(mode_i ? 4'h0 : 4'hf);
	endproperty
	property p_dec;
		$past(code_w && function_code_i == 4'hf) |->
			result_outputs_o == $past(mode_i ? a : a - 4'h1);
	endproperty

	a_pass: assert property (p_pass) else $error("result not passed through");
	a_hold: assert property (p_hold) else $error("held result changed");
	a_freeze: assert property (p_freeze) else $error("held result disturbed");
	a_gp: assert property (p_gp) else $error("generate or propagate wrong");
	a_cout: assert property (p_cout) else $error("carry-out wrong");
	a_add: assert property (p_add) else $error("sum or xnor wrong");
	a_sub: assert property (p_sub) else $error("difference or xor wrong");
	a_ones: assert property (p_ones) else $error("ones or zeros wrong");
	a_dec: assert property (p_dec) else $error("decrement or copy wrong");
endmodule

bind latching_four_bit_alu alu_latch_asserts #(.WIDTH(WIDTH)) i_alu_latch_asserts (.*);
`default_nettype wire

// File: alu_feed_model.sv
/* Upstream pipeline stage: launches operands and hold control on one edge.
   Assumes the bench sets its request word. */
`timescale 1ns/1ps
`default_nettype none
module alu_feed_model (
	// Clock and request {hold, cin_n, mode, code, b, a}
	input wire logic clk_sys_i,
	input wire logic [14:0] req_i,
	// Pins towards the ALU
	output logic [3:0] first_word_bits_o,
	output logic [3:0] second_word_lines_o,
	output logic [3:0] function_code_o,
	output logic mode_o,
	output logic carry_in_low_true_o,
	output logic hold_enable_o
);
	// ==========================================================
	// Register stage
	// Operands and hold control move together from req_i on each rising edge
	always_ff @(posedge clk_sys_i) begin
		{hold_enable_o, carry_in_low_true_o, mode_o, function_code_o, second_word_lines_o,
			first_word_bits_o} <= req_i;
	end
endmodule
`default_nettype wire

// File: tb_top.sv
/* Bench for the latching ALU: pins through the feed model, registers
   over AHB-Lite. Assumes the checker is bound to the design. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import alu_latch_pkg::*;
	// ==========================================================
	// Signals
	logic clk_sys, reset_n, ce, hsel, hwrite; // Clock and controls
	logic [14:0] req; // Feed request
	logic [31:0] haddr, hwdata, hrdata, rd; // Bus words
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [3:0] a_w, b_w, fc_w, q; // Pins and result
	logic m_w, cin_n_w, hold_w, gen, prop, cout_n, hready, hresp;
	int mismatches, comparisons;
	logic [3:0] codes [4] = '{4'h6, 4'h9, 4'h3, 4'hf}; // Codes under test
	logic [3:0] exp_q [8] = '{4'h3, 4'h4, 4'h4, 4'hb, 4'hf, 4'h0, 4'hb, 4'hc};
	logic [3:0] cout_v = 4'b0100; // Arithmetic carry-out per code

	alu_feed_model i_alu_feed_model (.clk_sys_i(clk_sys), .req_i(req),
		.first_word_bits_o(a_w), .second_word_lines_o(b_w), .function_code_o(fc_w),
		.mode_o(m_w), .carry_in_low_true_o(cin_n_w), .hold_enable_o(hold_w));
	latching_four_bit_alu i_latching_four_bit_alu (.clk_sys_i(clk_sys), .reset_n_i(reset_n),
		.ce_i(ce), .first_word_bits_i(a_w), .second_word_lines_i(b_w),
		.function_code_i(fc_w), .mode_i(m_w), .carry_in_low_true_i(cin_n_w),
		.hold_enable_i(hold_w), .result_outputs_o(q), .block_gen_o(gen),
		.block_prop_o(prop), .carry_out_top_n_o(cout_n), .hsel_i(hsel), .haddr_i(haddr),
		.htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
		.hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp));

	// ==========================================================
	// Tasks
	task automatic end_sim();
		$display("Mismatches %0d, comparisons %0d", mismatches, comparisons);
		if (mismatches == 0 && comparisons > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// Compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// Request pins, wait for feed and result stages
	task automatic ops(input logic h, cn, m, input logic [3:0] fc, b, a);
		req <= {h, cn, m, fc, b, a};
		repeat (3) @(posedge clk_sys);
	endtask

	// One single word transfer, read data left in rd
	task automatic ahb(input logic w, input logic [31:0] ad, input logic [31:0] wd);
		int n;
		n = 0;
		hsel <= 1'b1;
		haddr <= ad;
		hwrite <= w;
		htrans <= HTRANS_NONSEQ;
		@(posedge clk_sys);
		while (hready !== 1'b1 && n < 20) begin
			@(posedge clk_sys);
			n++;
		end
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		@(posedge clk_sys);
		while (hready !== 1'b1 && n < 40) begin
			@(posedge clk_sys);
			n++;
		end
		rd = hrdata;
		if (n >= 40) begin
			mismatches++;
			$display("[FAIL] %0t bus stalled", $time);
		end
	endtask

	// ==========================================================
	// Clock and watchdog
	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end
	initial begin
		repeat (3000) @(posedge clk_sys);
		mismatches++;
		end_sim();
	end

	// ==========================================================
	// Tests
	initial begin
		reset_n = 1'b0;
		ce = 1'b1;
		hsel = 1'b0;
		haddr = '0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = HSIZE_WORD;
		hwdata = '0;
		req = {1'b1, 1'b1, 13'h0};
		repeat (12) @(posedge clk_sys);
		reset_n <= 1'b1;
		repeat (2) @(posedge clk_sys);
		ahb(1'b0, ADDR_OPERAND, '0);
		chk(rd, 32'h0002_2000);
		chk(hresp, {31'h0, HRESP_OKAY});
		// Every listed code in both modes
		for (int i = 0; i < 8; i++) begin
			ops(1'b1, 1'b1, i[0], codes[i/2], 4'h7, 4'hc);
			chk(q, exp_q[i]);
			if (i[0] == 1'b0) begin
				chk(cout_n, cout_v[i/2]);
			end
		end
		// Carry-in adds one, look-ahead terms unchanged
		ops(1'b1, 1'b0, 1'b0, 4'h6, 4'h7, 4'hc);
		chk({prop, gen, q}, 6'h34);
		// Hold closed while new operands arrive
		ops(1'b0, 1'b1, 1'b0, 4'h6, 4'h0, 4'h0);
		chk(q, 4'h4);
		chk({prop, gen, cout_n}, 3'b001);
		ops(1'b0, 1'b1, 1'b1, 4'h9, 4'h5, 4'ha);
		chk(q, 4'h4);
		ops(1'b1, 1'b1, 1'b0, 4'h6, 4'h0, 4'h0);
		chk(q, 4'h0);
		// Clock enable low freezes the result and look-ahead output registers
		ce <= 1'b0;
		ops(1'b1, 1'b1, 1'b0, 4'h6, 4'h7, 4'hc);
		chk(q, 4'h0);
		chk({prop, gen, cout_n}, 3'b001);
		ce <= 1'b1;
		// Register source, then hold through the register
		ahb(1'b1, ADDR_OPERAND, 32'h0003_2621);
		repeat (3) @(posedge clk_sys);
		ahb(1'b0, ADDR_STATUS, '0);
		chk(rd, 32'h0000_00c3);
		ahb(1'b0, ADDR_OPERAND, '0);
		chk(rd, 32'h0003_2621);
		ahb(1'b0, 32'h0000_0010, '0);
		chk(rd, 32'h0);
		ahb(1'b1, ADDR_OPERAND, 32'h0001_2625);
		repeat (3) @(posedge clk_sys);
		ahb(1'b0, ADDR_STATUS, '0);
		chk(rd, 32'h0000_0043);
		ahb(1'b1, ADDR_OPERAND, 32'h0002_2000);
		repeat (3) @(posedge clk_sys);
		end_sim();
	end
endmodule
`default_nettype wire
